// [iad_consts.svh]
`ifndef IAD_CONSTS_SVH
`define IAD_CONSTS_SVH

// ****************************************************************
// Pointer map
// ****************************************************************
`define IAD_BANK_LAST    16'h0fff
`define IAD_LIN_BASE     16'h2000
`define IAD_LIN_LAST     16'h29af
`define IAD_FLASH_BIT    15
`define IAD_EE_PAGE      8'h70

// ****************************************************************
// Banked layout
// ****************************************************************
`define IAD_GPR_BYTES    12'h050
`define IAD_GPR_START    7'h20
`define IAD_PORT_LOC_HI  6'h00
`define IAD_READ_ZERO    8'h00

`endif

// [iad_pkg.sv]
package iad_pkg;

  typedef enum logic [1:0] {
    IAD_IDLE    = 2'b00,
    IAD_ACCESS  = 2'b01,
    IAD_STRETCH = 2'b10,
    IAD_SPARE   = 2'b11
  } iad_phase_e;

  typedef enum logic [2:0] {
    IAD_RG_BANKED = 3'b000,
    IAD_RG_LINEAR = 3'b001,
    IAD_RG_FLASH  = 3'b010,
    IAD_RG_EEPROM = 3'b011,
    IAD_RG_SELF   = 3'b100,
    IAD_RG_NONE   = 3'b101
  } iad_region_e;

  typedef logic [15:0] iad_ptr_t;

endpackage : iad_pkg

// [iad_linear_map.sv]
`timescale 1ns/1ps
`include "iad_consts.svh"

module iad_linear_map (
  input  wire logic [15:0] linPtr,
  output logic      [11:0] bankAddr
);
  import iad_pkg::*;

  logic [11:0] offset;
  logic [11:0] quot;
  logic [11:0] prod;
  logic [6:0]  idx;

  // Banks 0 to 30 each lend their 80 general purpose bytes; common bytes stay out of reach
  always_comb begin
    offset   = 12'(linPtr - `IAD_LIN_BASE);
    quot     = offset / `IAD_GPR_BYTES;
    prod     = 12'(quot[4:0]) * `IAD_GPR_BYTES;
    idx      = 7'(offset - prod);
    bankAddr = {quot[4:0], 7'(idx + `IAD_GPR_START)}; // R5 R7
  end

endmodule : iad_linear_map

// [iad_decoder.sv]
`timescale 1ns/1ps
`include "iad_consts.svh"

// What this block does
// (R1) An access to the indirect access port goes to the location held in the selected pointer.
// (R2) A pointer naming either port location reads zero and drops the write.
// (R3) The pointer is its high byte and low byte joined into one 16-bit address.
// (R4) Pointers 0x000 to 0xFFF reach banked data memory at the same absolute address.
// (R5) Pointers 0x2000 to 0x29AF walk the 80-byte RAM blocks of successive banks.
// (R6) Reads of unimplemented memory return 0x00.
// (R7) The linear range never reaches the 16 common bytes of a bank.
// (R8) With the top pointer bit set, the lower 15 bits are a flash word address.
// (R9) A flash read hands only the low eight bits of the word to the data path.
// (R10) Writes aimed at flash leave it unchanged.
// (R11) Any indirect flash access takes exactly one extra instruction cycle.
// (R12) High byte 0x70 selects EEPROM location given by the low byte.
// (R13) Writes aimed at EEPROM leave it unchanged.
// (R14) An indirect EEPROM read takes one extra instruction cycle.
// (R15) Pointers outside every region read zero and ignore writes.

module iad_decoder (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         reqValid,
  input  wire logic         reqWrite,
  input  wire logic         ptrSel,
  input  wire logic [7:0]   ptr0High,
  input  wire logic [7:0]   ptr0Low,
  input  wire logic [7:0]   ptr1High,
  input  wire logic [7:0]   ptr1Low,
  input  wire logic [7:0]   reqWrData,
  input  wire logic [7:0]   dmemRdData,
  input  wire logic [13:0]  flashRdWord,
  input  wire logic [7:0]   eeRdData,
  output logic              busy,
  output logic              done,
  output logic [7:0]        rdData,
  output logic              nvStretch,
  output logic [11:0]       dmemAddr,
  output logic              dmemRd,
  output logic              dmemWr,
  output logic [7:0]        dmemWrData,
  output logic [14:0]       flashAddr,
  output logic              flashRd,
  output logic [7:0]        eeAddr,
  output logic              eeRd
);
  import iad_pkg::*;

  typedef struct packed {
    iad_phase_e  phase;
    iad_region_e region;
    logic        isWrite;
    logic        stretch;
    logic        busy;
    logic        done;
    logic [7:0]  rdData;
    logic [11:0] dmemAddr;
    logic        dmemRd;
    logic        dmemWr;
    logic [7:0]  dmemWrData;
    logic [14:0] flashAddr;
    logic        flashRd;
    logic [7:0]  eeAddr;
    logic        eeRd;
  } iad_state_s;

  iad_state_s st_r;
  iad_state_s st_nxt;

  iad_ptr_t    ptr;
  iad_region_e region;
  logic [11:0] linAddr;

  // ****************************************************************
  // Pointer decode
  // ****************************************************************
  always_comb begin
    ptr = ptrSel ? {ptr1High, ptr1Low} : {ptr0High, ptr0Low}; // R1 R3
    if (ptr[`IAD_FLASH_BIT]) begin
      region = IAD_RG_FLASH; // R8
    end else if (ptr <= `IAD_BANK_LAST) begin
      // Port locations sit at the foot of every bank
      if (ptr[6:1] == `IAD_PORT_LOC_HI) begin
        region = IAD_RG_SELF; // R2
      end else begin
        region = IAD_RG_BANKED; // R4
      end
    end else if (ptr >= `IAD_LIN_BASE && ptr <= `IAD_LIN_LAST) begin
      region = IAD_RG_LINEAR; // R5
    end else if (ptr[15:8] == `IAD_EE_PAGE) begin
      region = IAD_RG_EEPROM; // R12
    end else begin
      region = IAD_RG_NONE; // R15
    end
  end

  iad_linear_map u_linear_map (
    .linPtr   (ptr),
    .bankAddr (linAddr)
  );

  // ****************************************************************
  // Access sequencing
  // ****************************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    case (st_r.phase)
      IAD_IDLE: begin
        if (reqValid) begin
          st_nxt.phase      = IAD_ACCESS;
          st_nxt.busy       = 1'b1;
          st_nxt.region     = region;
          st_nxt.isWrite    = reqWrite;
          st_nxt.dmemWrData = reqWrData;
          st_nxt.dmemAddr   = (region == IAD_RG_LINEAR) ? linAddr : ptr[11:0]; // R4 R5
          st_nxt.flashAddr  = ptr[14:0]; // R8
          st_nxt.eeAddr     = ptr[7:0]; // R12
          st_nxt.dmemRd     = !reqWrite &&
                              (region == IAD_RG_BANKED || region == IAD_RG_LINEAR);
          st_nxt.dmemWr     = reqWrite &&
                              (region == IAD_RG_BANKED || region == IAD_RG_LINEAR); // R2 R15
          // Non-volatile targets never see a write strobe
          st_nxt.flashRd    = !reqWrite && region == IAD_RG_FLASH; // R10
          st_nxt.eeRd       = !reqWrite && region == IAD_RG_EEPROM; // R13
          st_nxt.stretch    = (region == IAD_RG_FLASH) ||
                              (region == IAD_RG_EEPROM && !reqWrite); // R11 R14
        end
      end
      IAD_ACCESS: begin
        st_nxt.dmemWr = 1'b0;
        if (st_r.stretch) begin
          st_nxt.phase = IAD_STRETCH; // R11 R14
        end else begin
          st_nxt.phase   = IAD_IDLE;
          st_nxt.busy    = 1'b0;
          st_nxt.done    = 1'b1;
          st_nxt.dmemRd  = 1'b0;
          st_nxt.rdData  = (!st_r.isWrite && (st_r.region == IAD_RG_BANKED ||
                           st_r.region == IAD_RG_LINEAR)) ? dmemRdData
                                                           : `IAD_READ_ZERO; // R2 R6 R15
        end
      end
      IAD_STRETCH: begin
        st_nxt.phase   = IAD_IDLE;
        st_nxt.busy    = 1'b0;
        st_nxt.done    = 1'b1;
        st_nxt.stretch = 1'b0;
        st_nxt.flashRd = 1'b0;
        st_nxt.eeRd    = 1'b0;
        if (st_r.isWrite) begin
          st_nxt.rdData = `IAD_READ_ZERO;
        end else if (st_r.region == IAD_RG_FLASH) begin
          st_nxt.rdData = flashRdWord[7:0]; // R9
        end else begin
          st_nxt.rdData = eeRdData; // R12
        end
      end
      default: begin
        st_nxt.phase = IAD_IDLE;
        st_nxt.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy       = st_r.busy;
  assign done       = st_r.done;
  assign rdData     = st_r.rdData;
  assign nvStretch  = st_r.stretch;
  assign dmemAddr   = st_r.dmemAddr;
  assign dmemRd     = st_r.dmemRd;
  assign dmemWr     = st_r.dmemWr;
  assign dmemWrData = st_r.dmemWrData;
  assign flashAddr  = st_r.flashAddr;
  assign flashRd    = st_r.flashRd;
  assign eeAddr     = st_r.eeAddr;
  assign eeRd       = st_r.eeRd;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic takeReq;
  assign takeReq = reqValid && st_r.phase == IAD_IDLE;

  ptr_routes_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    takeReq && region == IAD_RG_BANKED |=> dmemAddr == $past(ptr[11:0]))
    else $error("banked pointer not routed");

  self_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    takeReq && ptr <= `IAD_BANK_LAST && ptr[6:1] == 6'h00
      |=> !dmemWr && !dmemRd ##1 done && rdData == 8'h00)
    else $error("port self access not suppressed");

  join_bytes_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    takeReq && ptrSel && !ptr1High[7] |=> eeAddr == $past(ptr1Low))
    else $error("pointer bytes not joined");

  linear_map_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    takeReq && ptr == 16'h2050 |=> dmemAddr == 12'h0a0)
    else $error("linear bank step wrong");

  linear_common_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    dmemRd && st_r.region == IAD_RG_LINEAR |-> dmemAddr[6:0] >= 7'h20 &&
      dmemAddr[6:0] <= 7'h6f)
    else $error("linear reaches common bytes");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
    takeReq && region == IAD_RG_NONE |=> !dmemWr ##1 done && rdData == 8'h00)
    else $error("unmapped access not zero");

  flash_low_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    st_r.phase == IAD_STRETCH && st_r.region == IAD_RG_FLASH && !st_r.isWrite
      |=> rdData == $past(flashRdWord[7:0]))
    else $error("flash low byte wrong");

  nv_no_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R10 R13
    takeReq && reqWrite && (ptr[15] || ptr[15:8] == 8'h70) |=> !dmemWr && !flashRd && !eeRd)
    else $error("write leaked to non-volatile");

  flash_stretch_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    takeReq && ptr[15] |=> !done ##1 !done ##1 done)
    else $error("flash access not one cycle longer");

  ee_stretch_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    takeReq && !reqWrite && ptr[15:8] == 8'h70 |=> eeRd ##1 eeRd && !done ##1 done)
    else $error("eeprom read not one cycle longer");

endmodule : iad_decoder

// [iad_mem_model.sv]
`timescale 1ns/1ps

module iad_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] dmemAddr,
  input  wire logic        dmemRd,
  input  wire logic [14:0] flashAddr,
  input  wire logic        flashRd,
  input  wire logic [7:0]  eeAddr,
  input  wire logic        eeRd,
  output logic      [7:0]  dmemRdData,
  output logic      [13:0] flashRdWord,
  output logic      [7:0]  eeRdData
);
  logic        flashSeen_r;
  logic        eeSeen_r;
  logic [7:0]  dPat;
  logic [13:0] fPat;
  logic [7:0]  ePat;

  always_ff @(posedge clk) begin
    flashSeen_r <= flashRd;
    eeSeen_r    <= eeRd;
  end

  // Outside the valid cycle the bus shows the inverse, so a stale sample cannot pass
  assign dPat        = dmemAddr[7:0] ^ {dmemAddr[11:8], 4'h5};
  assign fPat        = {flashAddr[13:8] ^ 6'h2a, flashAddr[7:0] ^ 8'hc3};
  assign ePat        = eeAddr ^ 8'h96;
  assign dmemRdData  = dmemRd ? dPat : ~dPat;
  assign flashRdWord = (flashRd && flashSeen_r) ? fPat : ~fPat;
  assign eeRdData    = (eeRd && eeSeen_r) ? ePat : ~ePat;
endmodule : iad_mem_model

// [iad_decoder_tb.sv]
`timescale 1ns/1ps

module iad_decoder_tb;
  typedef struct packed {logic [15:0] p; logic w; logic [3:0] lat;} iad_row_s;
  localparam iad_row_s ROWS [16] = '{
    '{16'h0123, 1'b0, 4'd2}, '{16'h0080, 1'b0, 4'd2}, '{16'h0001, 1'b1, 4'd2},
    '{16'h0fff, 1'b0, 4'd2}, '{16'h2000, 1'b0, 4'd2}, '{16'h2050, 1'b0, 4'd2},
    '{16'h29af, 1'b0, 4'd2}, '{16'h29b0, 1'b0, 4'd2}, '{16'h1000, 1'b0, 4'd2},
    '{16'h8005, 1'b0, 4'd3}, '{16'hffff, 1'b0, 4'd3}, '{16'h8005, 1'b1, 4'd3},
    '{16'h7012, 1'b0, 4'd3}, '{16'h7012, 1'b1, 4'd2}, '{16'h0123, 1'b1, 4'd2},
    '{16'h70ff, 1'b0, 4'd3}};
  logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, ptrSel = 1'b0;
  logic [7:0]  ptr0High = 8'h00, ptr0Low = 8'h00, ptr1High = 8'h00, ptr1Low = 8'h00;
  logic [7:0]  reqWrData = 8'h00, dmemRdData, eeRdData, rdData, dmemWrData, eeAddr;
  logic [13:0] flashRdWord;
  logic [11:0] dmemAddr;
  logic [14:0] flashAddr;
  logic        busy, done, nvStretch, dmemRd, dmemWr, flashRd, eeRd;
  int          errors = 0, cmp_count = 0;

  always #20 clk = ~clk;

  iad_decoder dut (.clk, .rst_n, .reqValid, .reqWrite, .ptrSel, .ptr0High, .ptr0Low,
    .ptr1High, .ptr1Low, .reqWrData, .dmemRdData, .flashRdWord, .eeRdData, .busy, .done,
    .rdData, .nvStretch, .dmemAddr, .dmemRd, .dmemWr, .dmemWrData, .flashAddr, .flashRd,
    .eeAddr, .eeRd);
  iad_mem_model mem (.clk, .dmemAddr, .dmemRd, .flashAddr, .flashRd, .eeAddr, .eeRd,
    .dmemRdData, .flashRdWord, .eeRdData);

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [11:0] linAddr(input logic [15:0] p);
    logic [15:0] off;
    off = p - 16'h2000;
    linAddr = {5'(off / 16'd80), 7'(off % 16'd80) + 7'h20};
  endfunction : linAddr

  function automatic logic isDmem(input logic [15:0] p);
    isDmem = (p <= 16'h0fff && p[6:1] != 6'h00) || (p >= 16'h2000 && p <= 16'h29af);
  endfunction : isDmem

  function automatic logic [7:0] expRd(input logic [15:0] p, input logic w);
    logic [11:0] a;
    a = (p <= 16'h0fff) ? p[11:0] : linAddr(p);
    expRd = 8'h00;
    if (w) return expRd;
    if (p[15]) expRd = p[7:0] ^ 8'hc3;
    else if (p[15:8] == 8'h70) expRd = p[7:0] ^ 8'h96;
    else if (isDmem(p)) expRd = a[7:0] ^ {a[11:8], 4'h5};
  endfunction : expRd

  // Starts in the cycle after an edge and returns in the done cycle, so calls run back to back
  task automatic access(input iad_row_s r, input logic sel, input logic poke);
    logic [15:0] n, nWr, nRd, nFl, nEe, nNv, nBs;
    logic [11:0] aSeen;
    n = 16'd1; nWr = 16'd0; nRd = 16'd0; nFl = 16'd0; nEe = 16'd0; nNv = 16'd0; nBs = 16'd0;
    aSeen = 12'h000;
    ptrSel = sel;
    {ptr0High, ptr0Low} = sel ? ~r.p : r.p;
    {ptr1High, ptr1Low} = sel ? r.p : ~r.p;
    reqWrite = r.w;
    reqWrData = r.p[7:0] ^ 8'h3c;
    reqValid = 1'b1;
    @(posedge clk) #1;
    reqValid = poke;
    ptrSel = poke ? ~sel : sel;
    forever begin
      nWr += dmemWr; nRd += dmemRd; nFl += flashRd; nEe += eeRd; nNv += nvStretch;
      nBs += busy;
      if (dmemRd || dmemWr) aSeen = dmemAddr;
      if (dmemWr) check(dmemWrData, r.p[7:0] ^ 8'h3c);
      if (flashRd) check(flashAddr, r.p[14:0]);
      if (eeRd) check(eeAddr, r.p[7:0]);
      if (done === 1'b1 || n > 6) break;
      @(posedge clk) #1;
      n++;
      // In the done cycle the next call owns reqValid, so it is left alone here
      if (done !== 1'b1) reqValid = 1'b0;
    end
    check(n, r.lat);
    check(rdData, expRd(r.p, r.w));
    check(nWr, r.w && isDmem(r.p));
    check(nRd, !r.w && isDmem(r.p));
    check(nFl, (!r.w && r.p[15]) ? 16'd2 : 16'd0);
    check(nEe, (!r.w && r.p[15:8] == 8'h70) ? 16'd2 : 16'd0);
    check(nNv, (r.lat == 4'd3) ? 16'd2 : 16'd0);
    check(nBs, r.lat - 4'd1);
    if (isDmem(r.p)) check(aSeen, (r.p <= 16'h0fff) ? r.p[11:0] : linAddr(r.p));
  endtask : access

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    #1;
    check({busy, done, rdData, nvStretch, dmemRd, dmemWr, flashRd, eeRd}, 16'h0000);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) access(ROWS[i], i[0], 1'b0);
    access('{16'h8005, 1'b0, 4'd3}, 1'b1, 1'b1);
    access('{16'h2050, 1'b0, 4'd2}, 1'b0, 1'b1);
    // The poke is still raised, so the done cycle presents a request that reset cuts
    @(posedge clk) #1;
    reqValid = 1'b0;
    rst_n = 1'b0;
    @(posedge clk) #1;
    check({busy, done, rdData, nvStretch, dmemRd, dmemWr, flashRd, eeRd}, 16'h0000);
    rst_n = 1'b1;
    access(ROWS[12], 1'b0, 1'b0);
    stop_test();
  end

  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule : iad_decoder_tb
